// ### core/nvi_slave.sv
// Two-wire serial slave front end of a 32K x 8 nonvolatile SRAM
// Functional notes
// - Seven-bit slave addressing only
// - Address byte: seven bits then direction
// - Acknowledge matching address, then serve master
// - Receiver pulls data low on ninth clock
// - Write: address bytes then burst data
// - Address increments on eighth falling edge
// - Address wraps to zero past top
// - Acknowledge every write byte unless refused
// - Bare read uses current address
// - Random read: address then restart, no write
// - Master NACK ends read; release line
// - Start/stop: data edge while clock high
// - Data changes only while clock low
// - Repeated start abandons transfer, expects address
// - Bytes eight bits, MSB first, then ack
// - NACK writes to protected locations
// - Master code then NACK enters high speed; code sets it on the eighth master code bit, before the NACK
// - High speed kept over restart, stop exits
// - Upper nibble picks memory or control
// - 1010 memory, 0011 control registers
// - Low bits match select pins, variant-dependent
// - Two address bytes, high byte first
`timescale 1ns/100ps
`include "nvi_consts.svh"
module nvi_slave (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    input  wire logic [2:0]  i_addr_select_pins,
    input  wire logic        i_two_pin_variant,
    input  wire logic        i_write_protect,
    output logic             o_hs_mode,
    output logic             o_busy,
    output logic [23:0]      o_wr_data,
    output logic             o_wr_valid,
    input  wire logic        i_wr_ready,
    output logic [15:0]      o_rd_addr,
    output logic             o_rd_req,
    input  wire logic [7:0]  i_rd_data
);
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic [2:0]  sel_sync0;
    logic [2:0]  sel_sync1;
    logic [1:0]  wp_sync;
    logic [1:0]  var_sync;
    logic        scl_d;
    logic        sda_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    nvi_pkg::nvi_state_e state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        is_read;
    logic        func_ctrl;
    logic [1:0]  addr_phase;
    logic [15:0] cur_addr;
    logic        ack_drive;
    logic        refused;
    logic        sel_match;
    logic [7:0]  rx_byte;
    logic        in_ack;
    logic        fifo_ready;
    logic        fifo_valid;
    logic [23:0] fifo_data;

    // Two-flop synchronisers for the pins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sel_sync0 <= 3'h0;
            sel_sync1 <= 3'h0;
            wp_sync   <= 2'h0;
            var_sync  <= 2'h0;
        end else begin
            wp_sync   <= {wp_sync[0], i_write_protect};
            var_sync  <= {var_sync[0], i_two_pin_variant};
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            sel_sync0 <= i_addr_select_pins;
            sel_sync1 <= sel_sync0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_rise  = scl_sync[1] && !scl_d;
    assign scl_fall  = !scl_sync[1] && scl_d;
    // Data edges with clock high
    assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign stop_det  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
    assign rx_byte   = {shreg[6:0], sda_sync[1]};

    // Device select compare, third bit ignored on two-pin variant
    assign sel_match = (shreg[3:2] == sel_sync1[2:1]) &&
                       (var_sync[1] ||
                        shreg[1] == sel_sync1[0]);
    assign in_ack = (state == nvi_pkg::ST_ACK) ||
                    (state == nvi_pkg::ST_MACK);

    // Bus busy flag, cleared only by stop
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else if (start_det) begin
            o_busy <= 1'b1;
        end else if (stop_det) begin
            o_busy <= 1'b0;
        end
    end

    // High speed mode tracking
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_hs_mode <= 1'b0;
        end else if (stop_det) begin
            o_hs_mode <= 1'b0;
        end else if (state == nvi_pkg::ST_DEVAD && bit_cnt == 4'h7 &&
                     scl_rise && rx_byte[7:3] == `NVI_HS_CODE) begin
            o_hs_mode <= 1'b1;
        end
    end

    // Main protocol sequencer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state      <= nvi_pkg::ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            is_read    <= 1'b0;
            func_ctrl  <= 1'b0;
            addr_phase <= 2'h0;
            cur_addr   <= 16'h0000;
            ack_drive  <= 1'b0;
            refused    <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_data  <= 24'h000000;
            o_rd_req   <= 1'b0;
            o_rd_addr  <= 16'h0000;
        end else begin
            o_rd_req <= 1'b0;
            if (o_wr_valid && fifo_ready) begin
                o_wr_valid <= 1'b0;
            end
            if (start_det) begin
                state   <= nvi_pkg::ST_DEVAD;
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
            end else if (stop_det) begin
                state     <= nvi_pkg::ST_IDLE;
                ack_drive <= 1'b0;
            end else begin
                unique case (state)
                    nvi_pkg::ST_IDLE: begin
                        ack_drive <= 1'b0;
                    end
                    nvi_pkg::ST_DEVAD, nvi_pkg::ST_RXBYT: begin
                        if (scl_rise) begin
                            shreg   <= rx_byte;
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            state   <= nvi_pkg::ST_ACK;
                            if (state == nvi_pkg::ST_DEVAD) begin
                                // Only 7-bit select plus direction
                                if ((shreg[7:4] == `NVI_FUNC_MEM ||
                                     shreg[7:4] == `NVI_FUNC_CTRL) &&
                                    sel_match) begin
                                    ack_drive  <= 1'b1;
                                    is_read    <= shreg[0];
                                    func_ctrl  <= (shreg[7:4] ==
                                                   `NVI_FUNC_CTRL);
                                    addr_phase <= 2'h0;
                                    refused    <= 1'b0;
                                    if (shreg[0]) begin
                                        o_rd_addr <= cur_addr;
                                        o_rd_req  <= 1'b1;
                                    end
                                end else begin
                                    state <= nvi_pkg::ST_IDLE;
                                end
                            end else if (addr_phase == 2'h0) begin
                                cur_addr[15:8] <= shreg;
                                addr_phase     <= 2'h1;
                                ack_drive      <= 1'b1;
                            end else if (addr_phase == 2'h1) begin
                                cur_addr[7:0] <= shreg;
                                addr_phase    <= 2'h2;
                                ack_drive     <= 1'b1;
                            end else if (wp_sync[1] && !func_ctrl) begin
                                ack_drive <= 1'b0;
                                refused   <= 1'b1;
                            end else begin
                                ack_drive  <= 1'b1;
                                o_wr_data  <= {func_ctrl, cur_addr[14:0],
                                               shreg};
                                o_wr_valid <= 1'b1;
                                cur_addr   <= cur_addr + 16'h0001;
                            end
                        end
                    end
                    nvi_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            ack_drive <= 1'b0;
                            if (refused) begin
                                state <= nvi_pkg::ST_IDLE;
                            end else if (is_read) begin
                                shreg   <= i_rd_data;
                                bit_cnt <= 4'h0;
                                state   <= nvi_pkg::ST_TXBYT;
                            end else begin
                                state <= nvi_pkg::ST_RXBYT;
                            end
                        end
                    end
                    nvi_pkg::ST_TXBYT: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                bit_cnt   <= 4'h0;
                                state     <= nvi_pkg::ST_MACK;
                                cur_addr  <= cur_addr + 16'h0001;
                                o_rd_addr <= cur_addr + 16'h0001;
                                o_rd_req  <= 1'b1;
                            end else begin
                                shreg   <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    nvi_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            shreg[0] <= sda_sync[1];
                        end
                        if (scl_fall) begin
                            if (shreg[0]) begin
                                state <= nvi_pkg::ST_IDLE;
                            end else begin
                                shreg <= i_rd_data;
                                state <= nvi_pkg::ST_TXBYT;
                            end
                        end
                    end
                    default: begin
                        state <= nvi_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin drive, changed only after a falling clock edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sda_out <= 1'b0;
            o_sda_oe  <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
            if (state == nvi_pkg::ST_TXBYT && !in_ack) begin
                o_sda_oe <= !shreg[7];
            end else if (state == nvi_pkg::ST_ACK) begin
                o_sda_oe <= ack_drive;
            end else begin
                o_sda_oe <= 1'b0;
            end
        end
    end

    // Write stream buffer toward the memory array
    nvi_fifo #(
        .WIDTH (24),
        .DEPTH (`NVI_FIFO_DEPTH),
        .AW    (`NVI_FIFO_AW)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_data  (o_wr_data),
        .i_valid (o_wr_valid),
        .o_ready (fifo_ready),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .i_ready (i_wr_ready)
    );
endmodule : nvi_slave

// Parameterised valid/ready FIFO
module nvi_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;

    assign full    = (wr_ptr[AW] != rd_ptr[AW]) &&
                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty   = (wr_ptr == rd_ptr);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (i_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (i_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (i_ready && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : nvi_fifo

// ### pkg/nvi_consts.svh
// Constants for the two-wire nvSRAM slave front end
`ifndef NVI_CONSTS_SVH
`define NVI_CONSTS_SVH
`define NVI_FUNC_MEM    4'hA
`define NVI_FUNC_CTRL   4'h3
`define NVI_HS_CODE     5'h01
`define NVI_ADDR_W      16
`define NVI_FIFO_DEPTH  32
`define NVI_FIFO_AW     5
`endif

// ### pkg/nvi_pkg.sv
// Types for the two-wire nvSRAM slave front end
package nvi_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_DEVAD = 6'b000010,
        ST_RXBYT = 6'b000100,
        ST_TXBYT = 6'b001000,
        ST_ACK   = 6'b010000,
        ST_MACK  = 6'b100000
    } nvi_state_e;
endpackage : nvi_pkg

// ### core/nvi_fifo.sv
// Write buffer logic is kept beside the slave sequencer

// ### dv/nvi_slave_properties.sv
// Port checks for the two-wire slave front end
`timescale 1ns/100ps
module nvi_slave_properties (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_hs_mode,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_sta;
        i_scl && $past(i_scl) && $fell(i_sda);
    endsequence
    sequence s_sto;
        i_scl && $past(i_scl) && $rose(i_sda);
    endsequence
    property p_low; o_sda_out == 1'b0; endproperty
    a_low: assert property (p_low) else $error("data out high");
    property p_oe_scl; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("drive edge");
    property p_oe_busy; o_sda_oe |-> o_busy; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("idle drive");
    property p_sta; s_sta |-> ##[1:6] o_busy; endproperty
    a_sta: assert property (p_sta) else $error("start missed");
    property p_sto; s_sto |-> ##[1:6] !o_busy; endproperty
    a_sto: assert property (p_sto) else $error("stop missed");
    property p_hs_exit; s_sto |-> ##[1:6] !o_hs_mode; endproperty
    a_hs_exit: assert property (p_hs_exit) else $error("hs kept");
    property p_hs_keep; s_sta ##0 o_hs_mode |=> o_hs_mode [*6]; endproperty
    a_hs_keep: assert property (p_hs_keep) else $error("hs lost");
    property p_hs_in; $rose(o_hs_mode) |-> o_busy && !o_sda_oe; endproperty
    a_hs_in: assert property (p_hs_in) else $error("hs entry");
    cover property (s_sta);
    cover property ($rose(o_hs_mode));
    cover property ($fell(o_sda_oe));
endmodule : nvi_slave_properties
bind nvi_slave nvi_slave_properties i_props (.i_clk, .i_reset, .i_scl,
    .i_sda, .o_sda_out, .o_sda_oe, .o_hs_mode, .o_busy);

// ### dv/nvi_master_model.sv
// Two-wire bus master model driving the clock and the data wire
`timescale 1ns/100ps
module nvi_master_model (
    input  wire logic i_clk,
    input  wire logic i_sda_oe,
    output logic      o_scl,
    output wire logic o_sda
);
    logic pull_low = 1'b0;
    initial o_scl = 1'b1;
    assign o_sda = !(pull_low || i_sda_oe); // Pulled-up wire
    task automatic w(input int n);
        repeat (n) @(negedge i_clk);
    endtask : w
    task automatic cond(input logic first, input logic last);
        w(3);
        pull_low = first;
        w(3);
        o_scl = 1'b1;
        w(4);
        pull_low = last; // Data edge while clock high
        w(4);
    endtask : cond
    task automatic bus_start();
        cond(1'b0, 1'b1);
        o_scl = 1'b0;
    endtask : bus_start
    task automatic bus_stop();
        cond(1'b1, 1'b0);
    endtask : bus_stop
    task automatic bit_io(input logic b, output logic r);
        w(3);
        pull_low = !b;
        w(3);
        o_scl = 1'b1;
        w(2);
        r = o_sda;
        o_scl = 1'b0;
    endtask : bit_io
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r); // Line released for the slot
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack_it, r);
    endtask : rd_byte
endmodule : nvi_master_model

// ### dv/nvsram_i2c_slave_interface_bench.sv
// Self-checking bench for the two-wire nvSRAM slave front end
`timescale 1ns/100ps
module nvsram_i2c_slave_interface_bench;
    logic        clk, reset, scl, sda, sda_out, sda_oe, two_pin, wp, hs;
    logic        busy, wr_valid, wr_ready, wr_prev, rd_req;
    logic [2:0]  sel;
    logic [23:0] wr_data;
    logic [15:0] rd_addr;
    logic [7:0]  rd_data;
    logic [23:0] words[$];
    int          checked, fail_count;
    nvi_master_model i_m (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl),
        .o_sda(sda));
    nvi_slave i_dut (.i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_select_pins(sel),
        .i_two_pin_variant(two_pin), .i_write_protect(wp), .o_hs_mode(hs),
        .o_busy(busy), .o_wr_data(wr_data), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_rd_addr(rd_addr), .o_rd_req(rd_req),
        .i_rd_data(rd_data));
    always #50 clk = !clk;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : pat
    always @(negedge clk) rd_data <= pat(rd_addr);
    always @(posedge clk) begin
        if (wr_valid && !wr_prev) words.push_back(wr_data);
        wr_prev <= wr_valid;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic [7:0] b, input logic exp);
        logic a;
        i_m.wr_byte(b, a);
        chk({23'h0, a}, {23'h0, exp});
    endtask : wb
    task automatic rb(input logic ack_it, input logic [7:0] exp);
        logic [7:0] d;
        i_m.rd_byte(ack_it, d);
        chk({16'h0, d}, {16'h0, exp});
    endtask : rb
    task automatic t_burst();
        i_m.bus_start();
        wb(8'hAA, 1'b1);
        wb(8'hFF, 1'b1);
        wb(8'hFE, 1'b1);
        for (int i = 0; i < 3; i++) wb(8'hC0 + 8'(i), 1'b1);
        i_m.bus_stop();
        chk(24'(words.size()), 24'h3);
        for (int i = 0; i < 3; i++) begin
            chk(words[i], {1'b0, 15'h7FFE + 15'(i), 8'hC0 + 8'(i)});
        end
        words.delete();
        i_m.bus_start();
        wb(8'hAB, 1'b1);
        rb(1'b1, pat(16'h0001));
        rb(1'b0, pat(16'h0002));
        i_m.bus_stop();
        $display("burst done");
    endtask : t_burst
    task automatic t_random();
        i_m.bus_start();
        wb(8'hAA, 1'b1);
        wb(8'h12, 1'b1);
        wb(8'h34, 1'b1);
        i_m.bus_start();
        chk({23'h0, busy}, 24'h1);
        wb(8'hAB, 1'b1);
        rb(1'b0, pat(16'h1234));
        i_m.bus_stop();
        chk({23'h0, busy}, 24'h0);
        chk(24'(words.size()), 24'h0);
        $display("random read done");
    endtask : t_random
    task automatic t_refuse();
        logic [7:0] bad[3] = '{8'h5A, 8'hF0, 8'hA4};
        foreach (bad[i]) begin
            i_m.bus_start();
            wb(bad[i], 1'b0);
            wb(8'h00, 1'b0);
            i_m.bus_stop();
        end
        two_pin = 1'b1;
        i_m.bus_start();
        wb(8'hA8, 1'b1);
        i_m.bus_stop();
        two_pin = 1'b0;
        i_m.bus_start();
        wb(8'h3A, 1'b1);
        i_m.bus_stop();
        wp = 1'b1;
        i_m.bus_start();
        wb(8'hAA, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h10, 1'b1);
        wb(8'h55, 1'b0);
        i_m.bus_stop();
        wp = 1'b0;
        chk(24'(words.size()), 24'h0);
        $display("refusals done");
    endtask : t_refuse
    task automatic t_hs();
        i_m.bus_start();
        wb(8'h0D, 1'b0);
        i_m.bus_start();
        chk({23'h0, hs}, 24'h1);
        wb(8'hAA, 1'b1);
        i_m.bus_stop();
        chk({23'h0, hs}, 24'h0);
        $display("high speed done");
    endtask : t_hs
    task automatic t_fifo();
        logic a;
        int n;
        wr_ready = 1'b0;
        i_m.bus_start();
        wb(8'hAA, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h00, 1'b1);
        for (int i = 0; i < 33; i++) i_m.wr_byte(8'(i), a);
        i_m.bus_stop();
        chk({23'h0, wr_valid}, 24'h1);
        wr_ready = 1'b1;
        for (n = 0; n < 200 && wr_valid !== 1'b0; n++) @(negedge clk);
        chk({23'h0, wr_valid}, 24'h0);
        if (n == 200) end_of_test();
        words.delete();
        $display("buffer done");
    endtask : t_fifo
    task automatic end_of_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {two_pin, wp, wr_prev, wr_ready} = 4'h1;
        sel = 3'h5;
        rd_data = 8'h00;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_burst();
        t_random();
        t_refuse();
        t_hs();
        t_fifo();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule : nvsram_i2c_slave_interface_bench
